/* File: hw/dpsf_port_ctrl.v */
// host-side controller driving one port of a dual-port ram with semaphore flags
`timescale 1ns/1ps
`include "dpsf_defs.vh"
module dpsf_port_ctrl #(
  parameter ADDR_W = 13,
  parameter DATA_W = 8
) (
  // clock and reset
  input  wire              sys_clk,
  input  wire              sys_rst,
  // user command port
  input  wire              cmdValid,
  input  wire [2:0]        cmdOp,
  input  wire [ADDR_W-1:0] cmdAddr,
  input  wire [DATA_W-1:0] cmdWrData,
  output reg               cmdReady,
  output reg               rspValid,
  output reg  [DATA_W-1:0] rspData,
  output reg               rspGranted,
  // device pins of one port
  output reg               memSelectN,
  output reg               semaphore_select_n,
  output reg               readWriteN,
  output reg               outEnableN,
  output reg  [ADDR_W-1:0] portAddr,
  output reg  [DATA_W-1:0] portDataOut,
  output reg               portDataOeN,
  input  wire [DATA_W-1:0] port_data_lines
);

  // sequencer states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WRITE = 3'h1;
  localparam [2:0] ST_READ  = 3'h2;
  localparam [2:0] ST_GAP   = 3'h3;
  localparam [2:0] ST_DONE  = 3'h4;

  // how one port access runs, one step per clock:
  //   setup  - selects, address and data go out; a write pulls read/write low
  //   strobe - read/write rises; that edge loads flag bit 0 or the memory byte
  //   hold   - selects, enables and our data driver are released, read data sampled
  // a write therefore keeps data on the lines across the rising read/write edge,
  // which is where the device latches it
  // an acquire is a write of 0, one gap step with both selects high, then a
  // read-back; the gap makes the device relatch the flag for that read
  // init writes 1 to all eight flags from index 0 upward, with a gap between
  // writes, so every request latch on this side ends up cleared
  // a release writes 1, which frees the token or withdraws a pending request
  // limitation: a lost acquire is not withdrawn here; the user must release,
  // or the token passes to this side later without anyone noticing
  // the two selects are never low together, and both are high whenever the
  // sequencer is idle, so the port rests in its standby state
  // all pins come from flip-flops: no decode glitch can pulse a select or
  // the read/write line between steps
  // trade-off: three steps per access is slower than the device needs,
  // but keeps the rising read/write edge a full clock away from the select and data edges

  reg [2:0]        state_reg;
  reg [2:0]        state_next;
  reg [1:0]        phase_reg;
  reg [2:0]        op_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [DATA_W-1:0] wdata_reg;
  reg [2:0]        semIdx_reg;

  // flag space for every command but the two plain memory ones
  wire              isSem     = (op_reg != `DPSF_CMD_MEM_RD) && (op_reg != `DPSF_CMD_MEM_WR);
  // the hold step closes every access
  wire              lastPhase = (phase_reg == `DPSF_PHASE_HOLD);
  // in flag space only the low index bits reach the pins; the rest stay low
  wire [ADDR_W-1:0] semAddr   = {{(ADDR_W-`DPSF_SEM_AW){1'b0}}, semIdx_reg};
  // address put on the pins for the current access
  wire [ADDR_W-1:0] pinAddr   = isSem ? semAddr : addr_reg;

  // next-state decode
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmdValid) begin
          if (cmdOp == `DPSF_CMD_MEM_RD || cmdOp == `DPSF_CMD_SEM_RD)
            state_next = ST_READ;
          else
            state_next = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (lastPhase) begin
          if (op_reg == `DPSF_CMD_ACQUIRE)
            state_next = ST_GAP;
          else if (op_reg == `DPSF_CMD_INIT && semIdx_reg != `DPSF_SEM_LAST)
            state_next = ST_GAP;
          else
            state_next = ST_DONE;
        end
      end
      ST_READ:  if (lastPhase) state_next = ST_DONE;
      ST_GAP:   state_next = (op_reg == `DPSF_CMD_ACQUIRE) ? ST_READ : ST_WRITE;
      ST_DONE:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // sequencer state, access step and command capture
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg  <= ST_IDLE;
      phase_reg  <= `DPSF_PHASE_SETUP;
      op_reg     <= `DPSF_CMD_MEM_RD;
      addr_reg   <= {ADDR_W{1'b0}};
      wdata_reg  <= {DATA_W{1'b0}};
      semIdx_reg <= {`DPSF_SEM_AW{1'b0}};
      cmdReady   <= 1'b0;
    end else begin
      state_reg <= state_next;
      // the step count restarts on every change of state
      phase_reg <= (state_next != state_reg) ? `DPSF_PHASE_SETUP : phase_reg + 2'h1;
      // ready only while idle; a taken command clears it on the same edge
      cmdReady  <= (state_next == ST_IDLE);
      if (state_reg == ST_IDLE && cmdValid) begin
        op_reg    <= cmdOp;
        addr_reg  <= cmdAddr;
        wdata_reg <= cmdWrData;
        // init ignores the given index and always starts at the first flag
        if (cmdOp == `DPSF_CMD_INIT)
          semIdx_reg <= {`DPSF_SEM_AW{1'b0}};
        else
          semIdx_reg <= cmdAddr[`DPSF_SEM_AW-1:0];
      end else if (state_reg == ST_WRITE && lastPhase && op_reg == `DPSF_CMD_INIT) begin
        // step to the next flag once the current write has finished
        semIdx_reg <= semIdx_reg + 3'h1;
      end
    end
  end

  // device pins; every one is a flip-flop
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      // both selects high: the port is deselected and in standby
      memSelectN         <= 1'b1;
      semaphore_select_n <= 1'b1;
      readWriteN         <= 1'b1;
      outEnableN         <= 1'b1;
      portAddr           <= {ADDR_W{1'b0}};
      portDataOut        <= {DATA_W{1'b0}};
      portDataOeN        <= 1'b1;
    end else begin
      case (state_reg)
        // write access: setup pulls read/write low, strobe raises it again
        ST_WRITE: begin
          // selects are mutually exclusive in every phase
          memSelectN         <= isSem;
          semaphore_select_n <= ~isSem;
          outEnableN         <= 1'b1;
          portDataOeN        <= 1'b0;
          portAddr           <= pinAddr;
          if (op_reg == `DPSF_CMD_ACQUIRE)
            portDataOut <= {DATA_W{1'b0}};
          else if (op_reg == `DPSF_CMD_RELEASE || op_reg == `DPSF_CMD_INIT)
            portDataOut <= {DATA_W{1'b1}};
          else
            portDataOut <= wdata_reg;
          // low for one step; data and select still stand at the rising edge
          readWriteN <= (phase_reg != `DPSF_PHASE_SETUP) ? 1'b1 : 1'b0;
          if (lastPhase) begin
            readWriteN         <= 1'b1;
            memSelectN         <= 1'b1;
            semaphore_select_n <= 1'b1;
            portDataOeN        <= 1'b1;
          end
        end
        // read access: our driver stays off while the device drives
        ST_READ: begin
          memSelectN         <= isSem;
          semaphore_select_n <= ~isSem;
          readWriteN         <= 1'b1;
          portDataOeN        <= 1'b1;
          portAddr           <= pinAddr;
          outEnableN         <= 1'b0;
          if (lastPhase) begin
            // drop select and enable so the next poll relatches
            outEnableN         <= 1'b1;
            semaphore_select_n <= 1'b1;
            memSelectN         <= 1'b1;
          end
        end
        // gap before an acquire read-back or the next init write: all deselected
        ST_GAP: begin
          memSelectN         <= 1'b1;
          semaphore_select_n <= 1'b1;
          outEnableN         <= 1'b1;
        end
        // idle and done: park every control pin inactive
        default: begin
          memSelectN         <= 1'b1;
          semaphore_select_n <= 1'b1;
          readWriteN         <= 1'b1;
          outEnableN         <= 1'b1;
          portDataOeN        <= 1'b1;
        end
      endcase
    end
  end

  // response; read data and grant stand until the next read completes
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rspValid   <= 1'b0;
      rspData    <= {DATA_W{1'b0}};
      rspGranted <= 1'b0;
    end else begin
      // one-cycle pulse as each command finishes
      rspValid <= (state_reg == ST_DONE);
      // sample on the hold step, after two steps of settled enable
      if (state_reg == ST_READ && lastPhase) begin
        rspData    <= port_data_lines;
        // a taken flag reads as all zeros; bit 0 alone decides the grant
        rspGranted <= isSem & ~port_data_lines[`DPSF_FLAG_BIT];
      end
    end
  end

endmodule // dpsf_port_ctrl

/* File: hw/dpsf_defs.vh */
// constants for the dual-port semaphore flag port controller
// Notes on behaviour
// - never assert both selects together
// - initialise by writing 1 to all flags
// - acquire: write 0, read back, 0 wins
// - release or withdraw by writing 1
`ifndef DPSF_DEFS_VH
`define DPSF_DEFS_VH
`define DPSF_CMD_MEM_RD  3'h0
`define DPSF_CMD_MEM_WR  3'h1
`define DPSF_CMD_SEM_RD  3'h2
`define DPSF_CMD_SEM_WR  3'h3
`define DPSF_CMD_ACQUIRE 3'h4
`define DPSF_CMD_RELEASE 3'h5
`define DPSF_CMD_INIT    3'h6
`define DPSF_SEM_COUNT   4'h8
`define DPSF_SEM_LAST    3'h7
`define DPSF_SEM_AW      3
`define DPSF_FLAG_BIT    0
`define DPSF_PHASE_SETUP 2'h0
`define DPSF_PHASE_STRB  2'h1
`define DPSF_PHASE_HOLD  2'h2
`endif

/* File: testbench/dpsf_port_ctrl_asserts.sv */
// pin-level checks on the port controller
`timescale 1ns/1ps
`include "dpsf_defs.vh"
module dpsf_port_ctrl_asserts #(parameter ADDR_W = 13, parameter DATA_W = 8) (
  // clock, command handshake and device pins
  input wire sys_clk, input wire sys_rst, input wire cmdValid, input wire [2:0] cmdOp,
  input wire cmdReady, input wire rspValid, input wire memSelectN,
  input wire semaphore_select_n, input wire readWriteN, input wire outEnableN,
  input wire [ADDR_W-1:0] portAddr, input wire [DATA_W-1:0] portDataOut,
  input wire portDataOeN
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire acc = cmdValid && cmdReady;
  // one step low, then data and a select must still stand as the strobe rises
  sequence wrHold;
    !readWriteN ##1 (readWriteN && !portDataOeN && !(memSelectN && semaphore_select_n));
  endsequence
  // enable low for two steps, then it must drop, else the device keeps the stale latch
  sequence rdHold; (!outEnableN && readWriteN)[*2] ##1 outEnableN; endsequence
  sequence semWr(b); ##[1:2] (!semaphore_select_n && !readWriteN && portDataOut[0] == b);
  endsequence
  a_sel_excl: assert property (memSelectN || semaphore_select_n)
    else $error("both selects low");
  a_oe_nodrive: assert property (!outEnableN |-> portDataOeN)
    else $error("controller drives during read");
  a_sem_addr: assert property (!semaphore_select_n |-> portAddr[ADDR_W-1:3] == 0)
    else $error("high address bits set in flag space");
  a_write_strobe: assert property ($fell(readWriteN) |-> wrHold)
    else $error("bad write strobe");
  a_read_hold: assert property ($fell(outEnableN) |-> rdHold)
    else $error("bad read enable");
  a_rsp_pulse: assert property (rspValid |=> !rspValid)
    else $error("response longer than one cycle");
  a_acq_order: assert property (acc && cmdOp == `DPSF_CMD_ACQUIRE |-> semWr(1'b0) ##[2:6] !outEnableN)
    else $error("acquire not write zero then read");
  a_rel_one: assert property (acc && cmdOp == `DPSF_CMD_RELEASE |-> semWr(1'b1))
    else $error("release does not write one");
endmodule // dpsf_port_ctrl_asserts
bind dpsf_port_ctrl dpsf_port_ctrl_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) dpsf_asserts_i (
  .sys_clk, .sys_rst, .cmdValid, .cmdOp, .cmdReady, .rspValid, .memSelectN, .semaphore_select_n,
  .readWriteN, .outEnableN, .portAddr, .portDataOut, .portDataOeN);

/* File: testbench/dpsf_dev_model.sv */
// device model: eight flags, a small memory and a far port
`timescale 1ns/1ps
module dpsf_dev_model (
  // near port pins and resolved data wire
  input wire memSelectN, input wire semaphore_select_n, input wire readWriteN,
  input wire outEnableN, input wire [12:0] portAddr, input wire [7:0] portDataOut,
  input wire portDataOeN, output wire [7:0] dataWire,
  // far port request latches (low requests) and its flag view
  input wire [7:0] farReqN, output wire [7:0] farFlag
);
  reg [7:0] mem [0:7];
  reg [7:0] reqN, ownA = 8'h00, ownB = 8'h00, outLat, lastV = 8'h00;
  integer i;
  wire [2:0] idx = portAddr[2:0];
  wire devOn = !outEnableN && readWriteN && (semaphore_select_n ^ memSelectN);
  wire [7:0] devVal = !semaphore_select_n ? outLat : mem[idx];
  assign dataWire = !portDataOeN ? portDataOut : devOn ? devVal : ~lastV;
  assign farFlag = ~ownB;
  // mutex: holder keeps token; pending side gets it on release; tie goes near
  always @(reqN or farReqN) for (i = 0; i < 8; i = i + 1) begin
    if (ownA[i] && reqN[i] === 1'b1) ownA[i] = 0;
    if (ownB[i] && farReqN[i]) ownB[i] = 0;
    if (!ownA[i] && !ownB[i]) begin
      ownA[i] = reqN[i] === 1'b0;
      ownB[i] = reqN[i] !== 1'b0 && farReqN[i] === 1'b0;
    end
  end
  // latches start unknown; rising strobe stores bit 0 or the byte
  always @(posedge readWriteN) begin
    if (semaphore_select_n === 1'b0 && memSelectN === 1'b1) reqN[idx] <= dataWire[0];
    else if (memSelectN === 1'b0 && semaphore_select_n === 1'b1) mem[idx] <= dataWire;
  end
  // read latch frozen while select and enable stay low
  always @(negedge (semaphore_select_n | outEnableN)) outLat <= {8{!ownA[idx]}};
  // released lines show the inverse of the last driven value
  always @(dataWire) if (!portDataOeN || devOn) lastV = dataWire;
endmodule // dpsf_dev_model

/* File: testbench/dpsf_port_ctrl_bench.sv */
// self-checking bench: port controller against the device model
`timescale 1ns/1ps
`include "dpsf_defs.vh"
module dpsf_port_ctrl_bench;
  reg         sys_clk = 0, sys_rst = 1, cmdValid = 0;
  reg  [2:0]  cmdOp = 0;
  reg  [12:0] cmdAddr = 0;
  reg  [7:0]  cmdWrData = 0, farReqN = 8'hff;
  wire        cmdReady, rspValid, rspGranted, memSelectN, semaphore_select_n;
  wire        readWriteN, outEnableN, portDataOeN;
  wire [12:0] portAddr;
  wire [7:0]  rspData, portDataOut, dataWire, farFlag;
  integer     errTotal = 0, checksDone = 0;
  always #50 sys_clk = ~sys_clk;
  dpsf_port_ctrl dpsf_port_ctrl_i (.sys_clk, .sys_rst, .cmdValid, .cmdOp, .cmdAddr, .cmdWrData,
    .cmdReady, .rspValid, .rspData, .rspGranted, .memSelectN, .semaphore_select_n, .readWriteN,
    .outEnableN, .portAddr, .portDataOut, .portDataOeN, .port_data_lines(dataWire));
  dpsf_dev_model dpsf_dev_model_i (.memSelectN, .semaphore_select_n, .readWriteN, .outEnableN,
    .portAddr, .portDataOut, .portDataOeN, .dataWire, .farReqN, .farFlag);
  task chk(input [7:0] e, input [7:0] g, input string what); begin
    checksDone = checksDone + 1;
    if (g !== e) begin
      errTotal = errTotal + 1;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  end endtask
  // one command, waiting for ready and response under a bound
  task cmd(input [2:0] op, input [12:0] a, input [7:0] d);
    integer n;
    begin
      n = 0;
      @(negedge sys_clk);
      while (cmdReady !== 1'b1 && n < 60) begin @(negedge sys_clk); n = n + 1; end
      cmdOp = op; cmdAddr = a; cmdWrData = d; cmdValid = 1;
      @(negedge sys_clk); cmdValid = 0;
      while (rspValid !== 1'b1 && n < 60) begin @(negedge sys_clk); n = n + 1; end
      chk(8'h01, {7'h00, rspValid}, "rspValid");
    end
  endtask
  task sr(input [2:0] i, input [7:0] e); begin
    cmd(`DPSF_CMD_SEM_RD, {10'h000, i}, 8'h00);
    chk(e, rspData, "flag read");
  end endtask
  task t_init; integer k; begin
    cmd(`DPSF_CMD_INIT, 13'h0000, 8'h00);
    for (k = 0; k < 8; k = k + 1) sr(k[2:0], 8'hff);
    $display("init done");
  end endtask
  task t_mem; begin
    cmd(`DPSF_CMD_MEM_WR, 13'h0005, 8'ha5);
    cmd(`DPSF_CMD_MEM_RD, 13'h0005, 8'h00);
    chk(8'ha5, rspData, "memory read");
    $display("memory done");
  end endtask
  task t_acq; begin
    cmd(`DPSF_CMD_ACQUIRE, 13'h1ffa, 8'h00);
    chk(8'h01, {7'h00, rspGranted}, "granted");
    chk(8'hff, farFlag, "far view");
    sr(3'h2, 8'h00);
    cmd(`DPSF_CMD_RELEASE, 13'h0002, 8'h00);
    sr(3'h2, 8'hff);
    $display("acquire done");
  end endtask
  task t_contend; begin
    farReqN = 8'hbf;
    cmd(`DPSF_CMD_ACQUIRE, 13'h0006, 8'h00);
    chk(8'hff, rspData, "losing read");
    chk(8'h00, {7'h00, rspGranted}, "lost grant");
    chk(8'hbf, farFlag, "far holds");
    farReqN = 8'hff;
    sr(3'h6, 8'h00);
    chk(8'hff, farFlag, "far released");
    cmd(`DPSF_CMD_SEM_WR, 13'h0006, 8'h01);
    cmd(`DPSF_CMD_SEM_WR, 13'h0000, 8'hfe);
    sr(3'h0, 8'h00);
    $display("contention done");
  end endtask
  task report_and_stop; begin
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end endtask
  // main sequence
  initial begin
    repeat (3) @(negedge sys_clk);
    sys_rst = 0;
    t_init;
    t_mem;
    t_acq;
    t_contend;
    report_and_stop;
  end
  // watchdog sized well past the expected run of under two hundred cycles
  initial begin #(3000 * 100); errTotal = errTotal + 1; report_and_stop; end
endmodule // dpsf_port_ctrl_bench
